// ### include/iwc_map.svh
// register offsets, field positions, reset values and counts of the watchdog configuration block
`ifndef IWC_MAP_SVH
`define IWC_MAP_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define IWC_OFS_CTRL    8'h00
`define IWC_OFS_STATUS  8'h04
`define IWC_OFS_RSTCTL  8'h08
`define IWC_OFS_CSTP    8'h0C
`define IWC_OFS_REFRESH 8'h10
`define IWC_OFS_MASK    8'h14
// ------------------------------------------------------------
// field positions (control register and option word share the divide and window fields; timeout is 1:0 in control, 3:2 in option)
// ------------------------------------------------------------
`define IWC_F_MODE      0
`define IWC_F_TOUT      3:2
`define IWC_F_CTRL_TOUT 1:0
`define IWC_F_CKS       7:4
`define IWC_F_WEND      9:8
`define IWC_F_WSTART    13:12
`define IWC_F_OPT_RSEL  14
`define IWC_F_OPT_LPST  15
`define IWC_F_SEL_BIT   7
`define IWC_F_CNT       13:0
`define IWC_F_REFRESH_ERROR_FLAG     14
`define IWC_F_UNDF      15
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define IWC_RST_CTRL    16'h3303
`define IWC_RST_BYTE    8'h00
`define IWC_RST_MASK    2'h0
// ------------------------------------------------------------
// refresh codes and divider/timeout counts
// ------------------------------------------------------------
`define IWC_REF_FIRST   8'h00
`define IWC_REF_SECOND  8'hFF
`define IWC_DIV_1       9'h001
`define IWC_DIV_16      9'h010
`define IWC_DIV_32      9'h020
`define IWC_DIV_64      9'h040
`define IWC_DIV_128     9'h080
`define IWC_DIV_256     9'h100
`define IWC_TOUT_0      14'h03FF
`define IWC_TOUT_1      14'h0FFF
`define IWC_TOUT_2      14'h1FFF
`define IWC_TOUT_3      14'h3FFF
`define IWC_RESP_OKAY   2'h0
`define IWC_RESP_SLVERR 2'h2
`endif

// ### include/iwc_pkg.sv
// types shared by the watchdog configuration block
package iwc_pkg;
    // active settings handed to the counter, reset and interrupt logic
    typedef struct packed {
        logic [3:0] clk_div;     // divide ratio code
        logic [1:0] timeout;     // timeout period code
        logic [1:0] win_start;   // window start code
        logic [1:0] win_end;     // window end code
        logic       rst_irq_sel; // 1: fault drives reset, 0: interrupt
        logic       lp_stop;     // halt count in low power states
    } iwc_cfg_t;
    // counter states, one-hot
    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_RUN  = 3'b010,
        ST_HALT = 3'b100
    } iwc_state_t;
endpackage : iwc_pkg

// ### testbench/tb.sv
// self-checking bench for the watchdog configuration block
`timescale 1ns/100ps
module tb;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic              mclk = 1'b0, srst = 1'b1;              // clock, sync reset
    logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;     // bus data lanes
    logic [3:0]        s_axi_wstrb = 4'hF;                   // all lanes written
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [15:0]       option_select_word0 = 16'h0001;       // option word
    logic              count_tick = 1'b1, lowpower_state = 1'b0;  // tick every cycle: short timeouts
    iwc_pkg::iwc_cfg_t cfg_active;                           // active settings
    logic              evt_underflow, evt_refresh_error, wdt_reset_out, wdt_irq_out, irq;
    logic [7:0]        n_undf, n_ref, n_rst, n_irq;          // pulse counts since reset
    logic [31:0]       rd_v;                                 // last read data
    logic [1:0]        rr_v, br_v;                           // last read and write responses
    int                fail_count = 0, check_count = 0;

    always #25 mclk = ~mclk;

    iwc_watchdog iwc_watchdog_i (.mclk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .option_select_word0, .count_tick, .lowpower_state,
        .cfg_active, .evt_underflow, .evt_refresh_error, .wdt_reset_out, .wdt_irq_out, .irq);

    // count one-cycle pulses so that none is missed between reads
    always @(posedge mclk) begin
        n_undf <= srst ? 8'h00 : n_undf + {7'h00, evt_underflow};
        n_ref  <= srst ? 8'h00 : n_ref + {7'h00, evt_refresh_error};
        n_rst  <= srst ? 8'h00 : n_rst + {7'h00, wdt_reset_out};
        n_irq  <= srst ? 8'h00 : n_irq + {7'h00, wdt_irq_out};
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    task automatic bail; // a wait ran out of its bound
        fail_count++;
        final_report();
    endtask : bail

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // readies are sampled at the falling edge, acted on at the next rise
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw;
        int   n;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; pa || pw; n++) begin
            if (n == 100) bail();
            @(negedge mclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            @(posedge mclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        for (n = 0; !s_axi_bvalid; n++) begin
            if (n == 100) bail();
            @(negedge mclk);
        end
        br_v = s_axi_bresp;
        @(posedge mclk);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n == 0 || !s_axi_arready; n++) begin
            if (n == 100) bail();
            @(negedge mclk);
        end
        @(posedge mclk);
        s_axi_arvalid <= 1'b0;
        for (n = 0; !s_axi_rvalid; n++) begin
            if (n == 100) bail();
            @(negedge mclk);
        end
        rd_v = s_axi_rdata;
        rr_v = s_axi_rresp;
        @(posedge mclk);
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic reset_with(input logic [15:0] opt);
        @(posedge mclk);
        option_select_word0 <= opt;
        srst <= 1'b1;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask : reset_with

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // auto start: settings follow the option word, control writes ignored
    task automatic t_auto;
        reset_with(16'hE128);
        chk({20'h0, cfg_active}, 32'h2A7);
        wr(8'h00, 32'h0000);
        chk({30'h0, br_v}, 32'h0);
        chk({20'h0, cfg_active}, 32'h2A7);
    endtask : t_auto

    // register start: reset value, every listed divide code, unmapped read
    task automatic t_regs;
        logic [3:0] codes [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'hF};
        reset_with(16'h0001);
        rd(8'h00);
        chk(rd_v, 32'h3303);
        chk({20'h0, cfg_active}, 32'h0FC);
        wr(8'h08, 32'h80);
        wr(8'h0C, 32'h80);
        foreach (codes[i]) begin
            wr(8'h00, 32'h1201 | {24'h0, codes[i], 4'h0});
            rd(8'h00);
            chk(rd_v, 32'h1201 | {24'h0, codes[i], 4'h0});
            chk({20'h0, cfg_active}, {20'h0, codes[i], 8'h5B});
        end
        rd(8'h20);
        chk({30'h0, rr_v}, 32'h2);
        wr(8'h20, 32'h0);
        chk({30'h0, br_v}, 32'h2);
    endtask : t_regs

    // refresh starts counting; an early second refresh is an error
    task automatic t_refresh;
        reset_with(16'h0001);
        wr(8'h10, 32'h00);
        wr(8'h10, 32'hFF);
        rd(8'h04);
        chk({31'h0, rd_v[13:0] < 14'h3FFF}, 32'h1);
        wr(8'h10, 32'h00);
        wr(8'h10, 32'hFF);
        repeat (3) @(posedge mclk);
        chk({24'h0, n_ref}, 32'h1);
        chk({16'h0, n_rst, n_irq}, 32'h0001);
        rd(8'h04);
        chk({31'h0, rd_v[14]}, 32'h1);
        wr(8'h14, 32'h4000);
        chk({31'h0, irq}, 32'h1);
        wr(8'h04, 32'h4000);
        chk({31'h0, irq}, 32'h0);
    endtask : t_refresh

    // low-power halt, then underflow routed to the reset output
    task automatic t_underflow;
        logic [31:0] keep;
        int          n;
        reset_with(16'hC000);
        @(posedge mclk);
        lowpower_state <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(8'h04);
        keep = rd_v;
        repeat (20) @(posedge mclk);
        rd(8'h04);
        chk({18'h0, rd_v[13:0]}, {18'h0, keep[13:0]});
        lowpower_state <= 1'b0;
        for (n = 0; n_undf == 8'h00; n++) begin
            if (n == 3000) bail();
            @(negedge mclk);
        end
        repeat (2) @(posedge mclk);
        chk({16'h0, n_rst, n_irq}, 32'h0100);
        chk({24'h0, n_undf}, 32'h1);
        rd(8'h04);
        chk({31'h0, rd_v[15]}, 32'h1);
    endtask : t_underflow

    initial begin
        t_auto();
        t_regs();
        t_refresh();
        t_underflow();
        final_report();
    end
endmodule : tb

// ### verilog/iwc_watchdog.sv
// watchdog configuration, refresh window, event outputs and register slave
`timescale 1ns/100ps
`include "iwc_map.svh"
// Contract
// - auto mode takes divide code from option word
// - two-bit timeout select, option or control
// - two-bit window start select, option or control
// - two-bit window end select, option or control
// - one bit routes fault to reset or interrupt
// - one bit halts count in low power
// - pulse outputs for underflow and refresh error
// - divide field bits 7:4 decode table
// - refresh is 00h then FFh, starts counting
// - refresh outside window is a refresh error
module iwc_watchdog (
    input  wire logic            mclk,
    input  wire logic            srst,
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    input  wire logic [15:0]     option_select_word0,
    input  wire logic            count_tick,
    input  wire logic            lowpower_state,
    output iwc_pkg::iwc_cfg_t    cfg_active,
    output logic                 evt_underflow,
    output logic                 evt_refresh_error,
    output logic                 wdt_reset_out,
    output logic                 wdt_irq_out,
    output logic                 irq
);
    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // divide code to prescaler length; reserved codes fall back to undivided
    function automatic logic [8:0] div_limit(input logic [3:0] code);
        unique case (code)
            4'h0: div_limit = `IWC_DIV_1;
            4'h2: div_limit = `IWC_DIV_16;
            4'h3: div_limit = `IWC_DIV_32;
            4'h4: div_limit = `IWC_DIV_64;
            4'h5: div_limit = `IWC_DIV_256;
            4'hF: div_limit = `IWC_DIV_128;
            default: div_limit = `IWC_DIV_1;
        endcase
    endfunction : div_limit
    // timeout code to reload value
    function automatic logic [13:0] reload_of(input logic [1:0] code);
        unique case (code)
            2'h0: reload_of = `IWC_TOUT_0;
            2'h1: reload_of = `IWC_TOUT_1;
            2'h2: reload_of = `IWC_TOUT_2;
            2'h3: reload_of = `IWC_TOUT_3;
        endcase
    endfunction : reload_of
    // quarter positions of the count: 0 -> 100%, 1 -> 75%, 2 -> 50%, 3 -> 25%
    function automatic logic [13:0] quarter(input logic [13:0] r, input logic [1:0] code);
        unique case (code)
            2'h0: quarter = r;
            2'h1: quarter = r - (r >> 2);
            2'h2: quarter = r >> 1;
            2'h3: quarter = r >> 2;
        endcase
    endfunction : quarter
    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16
    // ------------------------------------------------------------
    // option word capture and active settings
    // ------------------------------------------------------------
    logic [15:0] opt_r, opt_nxt;         // latched option word
    logic        opt_ld_r, opt_ld_nxt;   // option word captured
    logic [15:0] ctrl_r, ctrl_nxt;       // control register
    logic        rsel_r, rsel_nxt;       // reset control bit
    logic        lpst_r, lpst_nxt;       // count stop control bit
    logic        reg_mode;               // register-start mode
    // capture once, one edge after reset release, never under reset
    always_comb begin
        opt_ld_nxt = 1'b1;
        opt_nxt    = opt_ld_r ? opt_r : option_select_word0;
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            opt_ld_r <= 1'b0;
            opt_r    <= 16'h0000;
        end else begin
            opt_ld_r <= opt_ld_nxt;
            opt_r    <= opt_nxt;
        end
    end
    assign reg_mode = opt_r[`IWC_F_MODE];
    // mode picks the source of every setting
    always_comb begin
        if (reg_mode) begin
            cfg_active.clk_div     = ctrl_r[`IWC_F_CKS];
            cfg_active.timeout     = ctrl_r[`IWC_F_CTRL_TOUT];
            cfg_active.win_start   = ctrl_r[`IWC_F_WSTART];
            cfg_active.win_end     = ctrl_r[`IWC_F_WEND];
            cfg_active.rst_irq_sel = rsel_r;
            cfg_active.lp_stop     = lpst_r;
        end else begin
            cfg_active.clk_div     = opt_r[`IWC_F_CKS];
            cfg_active.timeout     = opt_r[`IWC_F_TOUT];
            cfg_active.win_start   = opt_r[`IWC_F_WSTART];
            cfg_active.win_end     = opt_r[`IWC_F_WEND];
            cfg_active.rst_irq_sel = opt_r[`IWC_F_OPT_RSEL];
            cfg_active.lp_stop     = opt_r[`IWC_F_OPT_LPST];
        end
    end
    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    logic [7:0]  awa_r, awa_nxt;         // held write address
    logic        awh_r, awh_nxt;         // write address held
    logic [31:0] wd_r, wd_nxt;           // held write data
    logic [3:0]  ws_r, ws_nxt;           // held strobes
    logic        wh_r, wh_nxt;           // write data held
    logic        bv_r, bv_nxt;
    logic [1:0]  br_r, br_nxt;
    logic        rv_r, rv_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [1:0]  rr_r, rr_nxt;
    logic        arm_r, arm_nxt;         // first refresh byte seen
    logic [1:0]  msk_r, msk_nxt;         // interrupt mask, status layout
    logic        do_wr;                  // write performed this cycle
    logic        do_refresh;             // complete refresh sequence
    logic [1:0]  w1c;                    // flag clear strobes
    logic [13:0] cnt_r, cnt_nxt;
    logic        uf_flag_r, uf_flag_nxt;
    logic        re_flag_r, re_flag_nxt;
    iwc_pkg::iwc_state_t st_r, st_nxt;
    assign s_axi_awready = !awh_r;
    assign s_axi_wready  = !wh_r;
    assign s_axi_arready = !rv_r;
    assign s_axi_bvalid  = bv_r;
    assign s_axi_bresp   = br_r;
    assign s_axi_rvalid  = rv_r;
    assign s_axi_rdata   = rd_r;
    assign s_axi_rresp   = rr_r;
    assign do_wr         = awh_r && wh_r && !bv_r;
    // address and data may come in either order; write once both are held
    always_comb begin
        awa_nxt = awa_r;  awh_nxt = awh_r;  wd_nxt = wd_r;  ws_nxt = ws_r;  wh_nxt = wh_r;
        bv_nxt = bv_r && !s_axi_bready;
        br_nxt = br_r;
        rv_nxt = rv_r && !s_axi_rready;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        ctrl_nxt = ctrl_r;  rsel_nxt = rsel_r;  lpst_nxt = lpst_r;  msk_nxt = msk_r;
        arm_nxt = arm_r;
        do_refresh = 1'b0;
        w1c = 2'b00;
        if (s_axi_awvalid && !awh_r) begin
            awa_nxt = s_axi_awaddr;
            awh_nxt = 1'b1;
        end
        if (s_axi_wvalid && !wh_r) begin
            wd_nxt = s_axi_wdata;
            ws_nxt = s_axi_wstrb;
            wh_nxt = 1'b1;
        end
        if (do_wr) begin
            awh_nxt = 1'b0;
            wh_nxt  = 1'b0;
            bv_nxt  = 1'b1;
            br_nxt  = `IWC_RESP_OKAY;
            unique case (awa_r)
                `IWC_OFS_CTRL:   ctrl_nxt = merge16(ctrl_r, wd_r, ws_r);
                `IWC_OFS_STATUS: if (ws_r[1]) w1c = {wd_r[`IWC_F_UNDF], wd_r[`IWC_F_REFRESH_ERROR_FLAG]};
                `IWC_OFS_RSTCTL: if (ws_r[0]) rsel_nxt = wd_r[`IWC_F_SEL_BIT];
                `IWC_OFS_CSTP:   if (ws_r[0]) lpst_nxt = wd_r[`IWC_F_SEL_BIT];
                `IWC_OFS_MASK:   if (ws_r[1]) msk_nxt = wd_r[`IWC_F_UNDF:`IWC_F_REFRESH_ERROR_FLAG];
                `IWC_OFS_REFRESH: if (ws_r[0]) begin  // any other byte breaks the sequence
                    do_refresh = arm_r && (wd_r[7:0] == `IWC_REF_SECOND);
                    arm_nxt    = (wd_r[7:0] == `IWC_REF_FIRST);
                end
                default: br_nxt = `IWC_RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && !rv_r) begin
            rv_nxt = 1'b1;
            rr_nxt = `IWC_RESP_OKAY;
            unique case (s_axi_araddr)
                `IWC_OFS_CTRL:    rd_nxt = {16'h0000, ctrl_r};
                `IWC_OFS_STATUS:  rd_nxt = {16'h0000, uf_flag_r, re_flag_r, cnt_r};
                `IWC_OFS_RSTCTL:  rd_nxt = {24'h000000, rsel_r, 7'h00};
                `IWC_OFS_CSTP:    rd_nxt = {24'h000000, lpst_r, 7'h00};
                `IWC_OFS_MASK:    rd_nxt = {16'h0000, msk_r, 14'h0000};
                `IWC_OFS_REFRESH: rd_nxt = 32'h000000FF;
                default: begin
                    rd_nxt = 32'h00000000;
                    rr_nxt = `IWC_RESP_SLVERR;
                end
            endcase
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            awa_r <= 8'h00;  awh_r <= 1'b0;  wd_r <= 32'h00000000;  ws_r <= 4'h0;  wh_r <= 1'b0;
            bv_r <= 1'b0;  br_r <= `IWC_RESP_OKAY;  rv_r <= 1'b0;  rd_r <= 32'h00000000;
            rr_r <= `IWC_RESP_OKAY;
            ctrl_r <= `IWC_RST_CTRL;  rsel_r <= 1'b0;  lpst_r <= 1'b0;  msk_r <= `IWC_RST_MASK;
            arm_r <= 1'b0;
        end else begin
            awa_r <= awa_nxt;  awh_r <= awh_nxt;  wd_r <= wd_nxt;  ws_r <= ws_nxt;  wh_r <= wh_nxt;
            bv_r <= bv_nxt;  br_r <= br_nxt;  rv_r <= rv_nxt;  rd_r <= rd_nxt;  rr_r <= rr_nxt;
            ctrl_r <= ctrl_nxt;  rsel_r <= rsel_nxt;  lpst_r <= lpst_nxt;  msk_r <= msk_nxt;
            arm_r <= arm_nxt;
        end
    end
    // ------------------------------------------------------------
    // down-counter, window check and fault outputs
    // ------------------------------------------------------------
    logic [8:0]  presc_r, presc_nxt;     // prescaler
    logic        uf_ev, re_ev;           // events this cycle
    logic        ev_uf_r, ev_re_r, rst_o_r, irq_o_r;
    logic [13:0] reload;
    logic        in_window, halted_lp, presc_hit;
    assign reload    = reload_of(cfg_active.timeout);
    assign halted_lp = cfg_active.lp_stop && lowpower_state;
    assign presc_hit = presc_r == (div_limit(cfg_active.clk_div) - 9'h001);
    // refresh allowed between start (upper) and end (lower) positions
    assign in_window = (cnt_r <= quarter(reload, cfg_active.win_start)) &&
                       (cnt_r >  quarter(reload, {1'b0, 1'b0} + cfg_active.win_end + 2'h1) ||
                        cfg_active.win_end == 2'h3 && cnt_r != 14'h0000);
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        presc_nxt = presc_r;
        uf_ev = 1'b0;
        re_ev = 1'b0;
        unique case (st_r)
            iwc_pkg::ST_WAIT: begin  // auto mode starts on its own, register mode on a refresh
                if (opt_ld_r && (!reg_mode || do_refresh)) begin
                    st_nxt    = iwc_pkg::ST_RUN;
                    cnt_nxt   = reload;
                    presc_nxt = 9'h000;
                end
            end
            iwc_pkg::ST_RUN: begin
                if (do_refresh) begin
                    re_ev     = !in_window;
                    cnt_nxt   = reload;
                    presc_nxt = 9'h000;
                    if (!in_window && reg_mode) st_nxt = iwc_pkg::ST_HALT;
                end else if (count_tick && !halted_lp) begin
                    presc_nxt = presc_hit ? 9'h000 : presc_r + 9'h001;
                    if (presc_hit) begin
                        uf_ev   = cnt_r == 14'h0000;
                        cnt_nxt = uf_ev ? reload : cnt_r - 14'h0001;
                        if (uf_ev && reg_mode) st_nxt = iwc_pkg::ST_HALT;
                    end
                end
            end
            iwc_pkg::ST_HALT: st_nxt = iwc_pkg::ST_HALT;  // only reset restarts
            default: st_nxt = iwc_pkg::ST_WAIT;
        endcase
        // set wins over a clear in the same cycle
        uf_flag_nxt = (uf_flag_r && !w1c[1]) || uf_ev;
        re_flag_nxt = (re_flag_r && !w1c[0]) || re_ev;
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r <= iwc_pkg::ST_WAIT;  cnt_r <= 14'h0000;  presc_r <= 9'h000;
            uf_flag_r <= 1'b0;  re_flag_r <= 1'b0;
            ev_uf_r <= 1'b0;  ev_re_r <= 1'b0;  rst_o_r <= 1'b0;  irq_o_r <= 1'b0;
        end else begin
            st_r <= st_nxt;  cnt_r <= cnt_nxt;  presc_r <= presc_nxt;
            uf_flag_r <= uf_flag_nxt;  re_flag_r <= re_flag_nxt;
            ev_uf_r <= uf_ev;
            ev_re_r <= re_ev;
            rst_o_r <= (uf_ev || re_ev) && cfg_active.rst_irq_sel;
            irq_o_r <= (uf_ev || re_ev) && !cfg_active.rst_irq_sel;
        end
    end
    assign evt_underflow     = ev_uf_r;
    assign evt_refresh_error = ev_re_r;
    assign wdt_reset_out     = rst_o_r;
    assign wdt_irq_out       = irq_o_r;
    assign irq               = |({uf_flag_r, re_flag_r} & msk_r);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_first_byte;
        do_wr && awa_r == `IWC_OFS_REFRESH && ws_r[0] && wd_r[7:0] == `IWC_REF_FIRST;
    endsequence
    sequence s_second_byte;
        do_wr && awa_r == `IWC_OFS_REFRESH && ws_r[0] && wd_r[7:0] == `IWC_REF_SECOND;
    endsequence
    chk_auto_divide: assert property (opt_ld_r && !reg_mode |-> cfg_active.clk_div == opt_r[7:4])
        else $error("divide code not from option word");
    chk_timeout_src: assert property (reg_mode |-> cfg_active.timeout == ctrl_r[1:0])
        else $error("timeout code not from control register");
    chk_win_start: assert property (!reg_mode |-> cfg_active.win_start == opt_r[13:12])
        else $error("window start not from option word");
    chk_win_end: assert property (reg_mode |-> cfg_active.win_end == ctrl_r[9:8])
        else $error("window end not from control register");
    chk_fault_route: assert property ((uf_ev || re_ev) |=> wdt_reset_out == $past(cfg_active.rst_irq_sel)
        && wdt_irq_out != wdt_reset_out)
        else $error("fault routed to wrong output");
    chk_lp_hold: assert property (st_r == iwc_pkg::ST_RUN && halted_lp && !do_refresh |=> $stable(cnt_r))
        else $error("count moved while low power stop");
    chk_event_pulse: assert property (evt_refresh_error |=> !evt_refresh_error)
        else $error("refresh error event not a pulse");
    chk_div_decode: assert property (cfg_active.clk_div == 4'hF |-> div_limit(cfg_active.clk_div) == 9'h080)
        else $error("divide code 1111 not by 128");
    chk_refresh_arm: assert property (s_first_byte |=> arm_r)
        else $error("first refresh byte did not arm");
    chk_refresh_start: assert property ((st_r == iwc_pkg::ST_WAIT && opt_ld_r && reg_mode && arm_r)
        ##0 s_second_byte |=> st_r == iwc_pkg::ST_RUN)
        else $error("refresh sequence did not start count");
    chk_window_err: assert property (st_r == iwc_pkg::ST_RUN && do_refresh && !in_window
        |=> evt_refresh_error && (wdt_reset_out || wdt_irq_out))
        else $error("refresh outside window not reported");
    chk_err_flag: assert property (evt_refresh_error |-> re_flag_r)
        else $error("refresh error flag not set");
    chk_reserved_div: assert property (cfg_active.clk_div == 4'h1 && st_r == iwc_pkg::ST_RUN |-> presc_r == 9'h000)
        else $error("reserved divide code not undivided");
endmodule : iwc_watchdog
